// *** dsl_pkg.sv ***
`default_nettype none
package dsl_pkg;

   // frame layout, most significant bit first
   localparam int unsigned FRAME_BITS   = 16;
   localparam logic [3:0]  LAST_BIT_CNT = 4'hF;
   localparam int unsigned BIT_CHAN     = 15;
   localparam int unsigned BIT_REFBUF   = 14;
   localparam int unsigned BIT_MODE_HI  = 13;
   localparam int unsigned BIT_MODE_LO  = 12;
   localparam int unsigned CODE_W       = 12;

   // resolution variants held in the control register
   localparam logic [1:0]  RES_12       = 2'h0;
   localparam logic [1:0]  RES_10       = 2'h1;
   localparam logic [1:0]  RES_8        = 2'h2;
   localparam logic [11:0] MASK_12      = 12'hFFF;
   localparam logic [11:0] MASK_10      = 12'hFFC;
   localparam logic [11:0] MASK_8       = 12'hFF0;
   localparam logic [1:0]  CTRL_RST     = 2'h0;

   // register byte addresses
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_IN_A     = 8'h04;
   localparam logic [7:0]  OFF_IN_B     = 8'h08;
   localparam logic [7:0]  OFF_OUT_A    = 8'h0C;
   localparam logic [7:0]  OFF_OUT_B    = 8'h10;
   localparam logic [7:0]  OFF_STATUS   = 8'h14;
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE  = 2'b10
   } dsl_state_e;

   typedef struct packed {
      logic        refbuf;
      logic        output_off_mode_hi;
      logic        output_off_mode_lo;
      logic [11:0] code;
   } dsl_chan_s;

   typedef struct packed {
      logic sync_n;
      logic sclk;
      logic din;
      logic load_outputs_n;
   } dsl_pins_s;

   localparam dsl_chan_s CHAN_RST = '0;
   localparam dsl_pins_s PINS_IDLE = 4'hF;

endpackage
`default_nettype wire

// *** dsl_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsl_sync2
   import dsl_pkg::*;
   (
   input  wire logic      clk_in,      // sampling clock
   input  wire logic      rst_n_in,    // synchronous reset, low active
   input  wire dsl_pins_s d_in,        // raw pins
   output var  dsl_pins_s q_out        // pins after two flops
   );

   dsl_pins_s meta;
   dsl_pins_s next_meta;
   dsl_pins_s next_q;

   always_comb begin
      next_meta = d_in;
      next_q    = meta;
   end

   // meta feeds only the second stage
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta  <= PINS_IDLE;
         q_out <= PINS_IDLE;
      end else begin
         meta  <= next_meta;
         q_out <= next_q;
      end
   end

endmodule
`default_nettype wire

// *** dsl_serial_port.sv ***
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dsl_serial_port
   import dsl_pkg::*;
   (
   input  wire logic        CLK_IN,            // 20 MHz system clock
   input  wire logic        RST_N_IN,          // sync reset, low active
   input  wire logic        SYNC_N_IN,         // frame select pin
   input  wire logic        SCLK_IN,           // serial clock pin
   input  wire logic        DIN_IN,            // serial data pin
   input  wire logic        LOAD_OUTPUTS_N_IN, // output load pin
   input  wire logic        HSEL_IN,           // ahb select
   input  wire logic [31:0] HADDR_IN,          // ahb address
   input  wire logic [1:0]  HTRANS_IN,         // ahb transfer type
   input  wire logic        HWRITE_IN,         // ahb write
   input  wire logic [2:0]  HSIZE_IN,          // ahb size
   input  wire logic [31:0] HWDATA_IN,         // ahb write data
   input  wire logic        HREADY_IN,         // ahb bus ready
   output logic             HREADYOUT_OUT,     // ahb slave ready
   output logic             HRESP_OUT,         // ahb response
   output logic [31:0]      HRDATA_OUT,        // ahb read data
   output logic [11:0]      DAC_A_CODE_OUT,    // channel a output code
   output logic [11:0]      DAC_B_CODE_OUT,    // channel b output code
   output logic [1:0]       REF_BUF_OUT,       // bit0 a, bit1 b buffered
   output logic [1:0]       OFF_MODE_A_OUT,    // channel a mode bits
   output logic [1:0]       OFF_MODE_B_OUT,    // channel b mode bits
   output logic             LINK_BUF_EN_OUT    // serial buffers powered
   );

   dsl_pins_s  raw;
   dsl_pins_s  pin;
   dsl_state_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [14:0] shreg, next_shreg;
   dsl_chan_s  in_a, in_b, out_a, out_b;
   dsl_chan_s  next_in_a, next_in_b, next_out_a, next_out_b;
   logic [1:0] pend, next_pend;
   logic [1:0] ctrl_res, next_ctrl_res;
   logic       prev_sync_n, prev_sclk;
   logic       sync_fall, sync_rise, sclk_fall, load_low;
   logic       frame_done;
   logic [15:0] word;
   logic       dp_wr, next_dp_wr;
   logic [7:0] dp_addr, next_dp_addr;
   logic [31:0] next_hrdata;
   logic       addr_ok;

   function automatic dsl_chan_s chan_from_word(input logic [15:0] w,
                                                input logic [1:0]  res);
      dsl_chan_s c;
      logic [11:0] m;
      m = MASK_12;
      if (res == RES_10) begin
         m = MASK_10;
      end else if (res == RES_8) begin
         m = MASK_8;
      end
      c.refbuf             = w[BIT_REFBUF];
      c.output_off_mode_hi = w[BIT_MODE_HI];
      c.output_off_mode_lo = w[BIT_MODE_LO];
      c.code               = w[CODE_W-1:0] & m;
      return c;
   endfunction

   assign raw.sync_n         = SYNC_N_IN;
   assign raw.sclk           = SCLK_IN;
   assign raw.din            = DIN_IN;
   assign raw.load_outputs_n = LOAD_OUTPUTS_N_IN;

   dsl_sync2 u_sync (
      .clk_in   (CLK_IN),
      .rst_n_in (RST_N_IN),
      .d_in     (raw),
      .q_out    (pin)
   );

   assign sync_fall = prev_sync_n & ~pin.sync_n;
   assign sync_rise = ~prev_sync_n & pin.sync_n;
   assign sclk_fall = prev_sclk & ~pin.sclk;
   assign load_low  = ~pin.load_outputs_n;
   assign word      = {shreg, pin.din};

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_shreg = shreg;
      next_in_a  = in_a;
      next_in_b  = in_b;
      next_out_a = out_a;
      next_out_b = out_b;
      next_pend  = pend;
      frame_done = 1'b0;
      case (state)
         ST_IDLE: begin
            if (sync_fall) begin
               next_state = ST_SHIFT;
               next_cnt   = 4'h0;
            end
         end
         ST_SHIFT: begin
            if (sclk_fall && cnt == LAST_BIT_CNT) begin
               frame_done = 1'b1;
               next_state = ST_DONE;
            end else if (sync_rise) begin
               next_state = ST_IDLE;
            end else if (sclk_fall) begin
               next_shreg = word[14:0];
               next_cnt   = cnt + 4'h1;
            end
         end
         ST_DONE: begin
            // edges ignored until select goes high again
            if (sync_rise) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // level only: serial activity has no say here
      if (load_low) begin
         next_out_a = in_a;
         next_out_b = in_b;
         next_pend  = 2'b00;
      end
      // set after clear so a new frame is never lost
      if (frame_done) begin
         if (word[BIT_CHAN]) begin
            next_in_b = chan_from_word(word, ctrl_res);
            next_pend[1] = 1'b1;
         end else begin
            next_in_a = chan_from_word(word, ctrl_res);
            next_pend[0] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state       <= ST_IDLE;
         cnt         <= 4'h0;
         shreg       <= 15'h0000;
         in_a        <= CHAN_RST;
         in_b        <= CHAN_RST;
         out_a       <= CHAN_RST;
         out_b       <= CHAN_RST;
         pend        <= 2'b00;
         prev_sync_n <= 1'b1;
         prev_sclk   <= 1'b1;
      end else begin
         state       <= next_state;
         cnt         <= next_cnt;
         shreg       <= next_shreg;
         in_a        <= next_in_a;
         in_b        <= next_in_b;
         out_a       <= next_out_a;
         out_b       <= next_out_b;
         pend        <= next_pend;
         prev_sync_n <= pin.sync_n;
         prev_sclk   <= pin.sclk;
      end
   end

   assign DAC_A_CODE_OUT  = out_a.code;
   assign DAC_B_CODE_OUT  = out_b.code;
   assign REF_BUF_OUT     = {out_b.refbuf, out_a.refbuf};
   assign OFF_MODE_A_OUT  = {out_a.output_off_mode_hi, out_a.output_off_mode_lo};
   assign OFF_MODE_B_OUT  = {out_b.output_off_mode_hi, out_b.output_off_mode_lo};
   assign LINK_BUF_EN_OUT = (state == ST_SHIFT);

   // ahb-lite slave, zero wait states, always OKAY
   assign addr_ok       = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT     = 1'b0;

   always_comb begin
      next_dp_wr    = addr_ok & HWRITE_IN & (HSIZE_IN == HSIZE_WORD);
      next_dp_addr  = HADDR_IN[7:0];
      next_ctrl_res = ctrl_res;
      next_hrdata   = HRDATA_OUT;
      if (dp_wr && dp_addr == OFF_CTRL) begin
         next_ctrl_res = HWDATA_IN[1:0];
      end
      // next values used so a read right after a write sees it
      if (addr_ok && !HWRITE_IN) begin
         if (HADDR_IN[7:0] == OFF_CTRL) begin
            next_hrdata = {30'h0, next_ctrl_res};
         end else if (HADDR_IN[7:0] == OFF_IN_A) begin
            next_hrdata = {17'h0, next_in_a};
         end else if (HADDR_IN[7:0] == OFF_IN_B) begin
            next_hrdata = {17'h0, next_in_b};
         end else if (HADDR_IN[7:0] == OFF_OUT_A) begin
            next_hrdata = {17'h0, next_out_a};
         end else if (HADDR_IN[7:0] == OFF_OUT_B) begin
            next_hrdata = {17'h0, next_out_b};
         end else if (HADDR_IN[7:0] == OFF_STATUS) begin
            next_hrdata = {24'h0, next_pend, next_state, next_cnt};
         end else begin
            next_hrdata = 32'h0;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         dp_wr      <= 1'b0;
         dp_addr    <= 8'h00;
         ctrl_res   <= CTRL_RST;
         HRDATA_OUT <= 32'h0;
      end else begin
         dp_wr      <= next_dp_wr;
         dp_addr    <= next_dp_addr;
         ctrl_res   <= next_ctrl_res;
         HRDATA_OUT <= next_hrdata;
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   chk_load_copy: assert property (
      load_low [*2] |-> out_a == $past(in_a) && out_b == $past(in_b))
      else $error("outputs did not follow inputs under load");
   chk_hold_high: assert property (
      !load_low |=> $stable(out_a) && $stable(out_b))
      else $error("output changed with load high");
   chk_pend_set: assert property (
      frame_done && !word[BIT_CHAN] |=> pend[0] && in_a != $past(in_a) ||
      pend[0])
      else $error("new data flag not set");
   chk_buf_power: assert property (
      state == ST_IDLE && sync_fall |=> LINK_BUF_EN_OUT && cnt == 4'h0)
      else $error("buffers not enabled on select fall");
   chk_frame_end: assert property (
      state == ST_SHIFT && sclk_fall && cnt == LAST_BIT_CNT |=>
      state == ST_DONE ##1 !LINK_BUF_EN_OUT)
      else $error("frame did not end at sixteenth edge");
   chk_abort_keep: assert property (
      state == ST_SHIFT && sync_rise && !(sclk_fall && cnt == LAST_BIT_CNT)
      |=> state == ST_IDLE && $stable(in_a) && $stable(in_b))
      else $error("abort changed registers");
   chk_done_ignore: assert property (
      state == ST_DONE |=> $stable(in_a) && $stable(in_b) && $stable(cnt))
      else $error("edges after frame not ignored");
   chk_power_down: assert property (
      state == ST_DONE |-> !LINK_BUF_EN_OUT)
      else $error("buffers on after write");
   chk_chan_select: assert property (
      frame_done && !word[BIT_CHAN] |=> in_a.refbuf == $past(word[BIT_REFBUF])
      && in_a.output_off_mode_hi == $past(word[BIT_MODE_HI]) && $stable(in_b))
      else $error("wrong channel or fields");
   chk_res_mask: assert property (
      frame_done && word[BIT_CHAN] && ctrl_res == RES_8 |=>
      in_b.code[3:0] == 4'h0 && in_b.code[11:4] == $past(word[11:4]))
      else $error("resolution mask wrong");
   chk_pass_thru: assert property (
      frame_done && !word[BIT_CHAN] && load_low ##1 load_low [*2] |->
      out_a == in_a)
      else $error("frame did not pass through with load low");
   chk_reset_clear: assert property (disable iff (1'b0)
      !RST_N_IN |=> in_a == CHAN_RST && out_b == CHAN_RST && state == ST_IDLE)
      else $error("reset did not clear registers");

endmodule
`default_nettype wire

// *** dsl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model
   import dsl_pkg::*;
   (
   input  wire logic clk_in,     // bench clock
   output var  logic sync_n_out, // frame select
   output var  logic sclk_out,   // serial clock, idles high
   output var  logic din_out     // serial data
   );
   // four clocks low, four high: 400 ns period, well under 30 MHz
   localparam int HALF = 4;
   initial begin
      sync_n_out = 1'b1;
      sclk_out   = 1'b1;
      din_out    = 1'b0;
   end
   // nb data bits msb first, then ex stray edges carrying noise
   task automatic send(input logic [15:0] w, input int nb, input int ex);
      int i;
      sync_n_out <= 1'b0;
      for (i = 0; i < nb + ex; i++) begin
         din_out <= (i < nb) ? w[15-i] : ~din_out;
         repeat (HALF) @(posedge clk_in);
         sclk_out <= 1'b0;
         repeat (HALF) @(posedge clk_in);
         sclk_out <= 1'b1;
      end
      sync_n_out <= 1'b1;
      // released data line must not keep showing the last bit
      din_out    <= ~din_out;
      repeat (HALF) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// *** dual_dac_serial_load_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_port_tb;
   import dsl_pkg::*;
   logic        clk, rst_n, load_n, hsel, hwrite, hready, hresp, link_en;
   logic        sync_n, sclk, din;
   logic [1:0]  htrans, ref_buf, mode_a, mode_b, res;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [11:0] code_a, code_b;
   logic [15:0] w;
   logic [14:0] exp_in [2];
   logic [14:0] exp_out [2];
   int          errors, n_tests, seed, k, nb;

   dsl_host_model u_host (.clk_in(clk), .sync_n_out(sync_n),
      .sclk_out(sclk), .din_out(din));
   dsl_serial_port u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .SYNC_N_IN(sync_n),
      .SCLK_IN(sclk), .DIN_IN(din), .LOAD_OUTPUTS_N_IN(load_n),
      .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .HRDATA_OUT(hrdata), .DAC_A_CODE_OUT(code_a), .DAC_B_CODE_OUT(code_b),
      .REF_BUF_OUT(ref_buf), .OFF_MODE_A_OUT(mode_a),
      .OFF_MODE_B_OUT(mode_b), .LINK_BUF_EN_OUT(link_en));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [14:0] fold(input logic [15:0] v,
                                        input logic [1:0] r);
      logic [11:0] m;
      m = (r == RES_10) ? MASK_10 : (r == RES_8) ? MASK_8 : MASK_12;
      return {v[14:12], v[11:0] & m};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // select stays up between calls; idle htrans marks no transfer
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      do begin @(posedge clk); end while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); end while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic check_outs();
      chk({17'h0, ref_buf[0], mode_a, code_a}, {17'h0, exp_out[0]});
      chk({17'h0, ref_buf[1], mode_b, code_b}, {17'h0, exp_out[1]});
   endtask

   task automatic frame(input logic [15:0] v, input int n, input int ex);
      fork
         u_host.send(v, n, ex);
         begin
            repeat (8) @(posedge clk);
            chk({31'h0, link_en}, 32'h1);
         end
      join
      chk({31'h0, link_en}, 32'h0);
      if (n == 16) begin
         exp_in[v[15]] = fold(v, res);
         if (load_n == 1'b0) exp_out[v[15]] = exp_in[v[15]];
      end
      ahb(1'b0, OFF_IN_A, 32'h0, rd);
      chk(rd, {17'h0, exp_in[0]});
      ahb(1'b0, OFF_IN_B, 32'h0, rd);
      chk(rd, {17'h0, exp_in[1]});
      check_outs();
   endtask

   task automatic end_of_test();
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #1_000_000;
      errors++;
      end_of_test();
   end

   initial begin
      seed = 32'h7f870501;
      errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      load_n = 1'b1;
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      res = RES_12;
      exp_in = '{default: '0};
      exp_out = '{default: '0};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // every register, and one unmapped word, reads zero after reset
      for (k = 0; k <= 8'h18; k += 4) begin
         ahb(1'b0, k[7:0], 32'h0, rd);
         chk(rd, 32'h0);
      end
      check_outs();
      for (k = 0; k < 4; k++) begin
         res = k[1:0];
         ahb(1'b1, OFF_CTRL, {30'h0, res}, rd);
         ahb(1'b0, OFF_CTRL, 32'h0, rd);
         chk(rd, {30'h0, res});
         w = $random(seed);
         frame(w, 16, 0);
      end
      res = RES_12;
      ahb(1'b1, OFF_CTRL, 32'h0, rd);
      w = $random(seed);
      frame({1'b0, w[14:0]}, 16, 0);
      w = $random(seed);
      frame({1'b1, w[14:0]}, 16, 0);
      load_n <= 1'b0;
      repeat (4) @(posedge clk);
      load_n <= 1'b1;
      repeat (6) @(posedge clk);
      exp_out = exp_in;
      check_outs();
      w = $random(seed);
      frame(w, 15, 0);
      w = $random(seed);
      frame(w, 16, 3);
      load_n <= 1'b0;
      repeat (6) @(posedge clk);
      // load low copies the frame that was held back above
      exp_out = exp_in;
      check_outs();
      w = $random(seed);
      frame(w, 16, 0);
      load_n <= 1'b1;
      repeat (8) begin
         w = $random(seed);
         nb = ($random(seed) & 1) ? 16 : 1 + ($unsigned($random(seed)) % 15);
         frame(w, nb, 0);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
